//--- logic/e1p_pkg.sv
// Shared constants and types of the framer pin block
package e1p_pkg;

    // Clock and line rates
    localparam int unsigned CLK_HZ       = 125_000_000;
    localparam int unsigned LINE_RATE_HZ = 2_048_000;
    localparam int unsigned BP_CLK_HZ    = 4_096_000;

    // Phase increments of the 32-bit rate generators
    localparam logic [31:0] LINE_NCO_INC = 32'((64'(LINE_RATE_HZ) << 32) / 64'(CLK_HZ));
    localparam logic [31:0] BP_NCO_INC   = 32'((64'(BP_CLK_HZ) << 32) / 64'(CLK_HZ));
    localparam logic [31:0] LINE_ALIGN_PHASE = 32'h2000_0000;
    localparam logic [1:0]  LATE_PHASE       = 2'h3;

    // Register bus layout
    localparam int unsigned AXI_ADDR_W   = 8;
    localparam logic [7:0]  CTRL_OFS     = 8'h10;
    localparam logic [7:0]  STATUS_OFS   = 8'h14;
    localparam logic [7:0]  LINK_CFG_OFS = 8'h18;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // Control register fields
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam int unsigned CTRL_RATE_LSB   = 0;
    localparam int unsigned CTRL_MF_SRC_BIT = 6;
    localparam logic [3:0]  LINK_CFG_RESET  = 4'h0;

    // Status register fields
    localparam int unsigned ST_SYNC_BIT     = 0;
    localparam int unsigned ST_MF_SRC_BIT   = 1;
    localparam int unsigned ST_RX_FRAME_LSB = 4;
    localparam int unsigned ST_TX_FRAME_LSB = 8;

    // Processor port
    localparam logic [4:0]  PORT_CTRL_ADDR = 5'h10;

    // Frame structure
    localparam logic [7:0]  FRAME_BIT_LAST = 8'hFF;
    localparam logic [3:0]  MF_FRAME_LAST  = 4'hF;
    localparam logic [8:0]  BP_COUNT_LAST  = 9'h1FF;
    localparam logic [7:0]  SA_FIRST_BIT   = 8'h03;
    localparam logic [2:0]  RATE_SEL_MAX   = 3'h4;

    // Processor port access states
    typedef enum logic [2:0] {
        P_IDLE  = 3'b001,
        P_READ  = 3'b010,
        P_WRITE = 3'b100
    } e1p_port_state_e;

endpackage

//--- logic/e1p_line_decode.sv
// Zero-substitution line decoder for the dual-rail received bit stream
`timescale 1ns/1ps
module e1p_line_decode (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic bit_en,
    input  wire logic mark_pos,
    input  wire logic mark_neg,
    output logic      data_out
);
    logic       last_pos;
    logic [3:0] delay;

    // Same polarity as the last mark is a substitution
    wire mark      = mark_pos | mark_neg;
    wire violation = mark & (mark_pos == last_pos);

    // Four-bit delay lets a violation wipe the group
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_pos <= 1'b0;
            delay    <= 4'h0;
            data_out <= 1'b0;
        end else if (bit_en) begin
            data_out <= delay[3];
            delay    <= violation ? 4'h0 : {delay[2:0], mark};
            if (mark) begin
                last_pos <= mark_pos;
            end
        end
    end
endmodule

//--- logic/e1p_framer_pins.sv
// Pin-level processor port, receive link and multiframe timing of the E1 framer
//
// Contract
// - Gapped link clock at 4 to 20 kHz; far end samples on its rising edge.
// - Receive link output carries decoded line bits at 2.048 Mbit/s.
// - Receive link output changes at each recovered clock rising edge.
// - Recovered 2.048 MHz clock is driven out and times line data capture.
// - Low pulse on transmit alignment input sets the transmit multiframe boundary.
// - With alignment input high, transmit multiframe timing runs free.
// - Marker pulses at receive multiframe end; next stream frame is frame zero.
// - Marker follows CRC multiframe when source bit is 1, signalling when 0.
// - Sync source high makes backplane clock and pulse inputs; low drives them.
// - Data bus is eight bits, upper lanes join lower, top lane is MSB.
// - Chip select high keeps the port idle and data pins released.
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module e1p_framer_pins
#(
    parameter int PORT_DEPTH = 32
) (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [e1p_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [e1p_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic                          rx_line_pos,
    input  wire logic                          rx_line_neg,
    output logic                               recovered_line_clock,
    output logic                               rx_link_serial_out,
    output logic                               rx_link_gapped_clock,
    output logic                               rx_pcm_stream_out,
    output logic                               rx_multiframe_marker,
    input  wire logic                          tx_multiframe_align_n,
    output logic                               tx_multiframe_boundary,
    input  wire logic                          sync_source_select,
    input  wire logic                          backplane_clock_4m_in,
    output logic                               backplane_clock_4m_out,
    output logic                               backplane_clock_4m_oe,
    input  wire logic                          backplane_frame_pulse_n_in,
    output logic                               backplane_frame_pulse_n_out,
    output logic                               backplane_frame_pulse_n_oe,
    input  wire logic                          port_chip_select_n,
    input  wire logic                          port_read_strobe_n,
    input  wire logic                          port_dir_write_n,
    input  wire logic [4:0]                    addr_ctrl_inputs,
    input  wire logic                          bus_style_select,
    input  wire logic [3:0]                    data_bus_lower_in,
    output logic [3:0]                         data_bus_lower_out,
    output logic [3:0]                         data_bus_lower_oe,
    input  wire logic [3:0]                    data_bus_upper_in,
    output logic [3:0]                         data_bus_upper_out,
    output logic [3:0]                         data_bus_upper_oe
);
    import e1p_pkg::*;

    function automatic logic rose(input logic prev, input logic cur);
        return ~prev & cur;
    endfunction

    function automatic logic fell(input logic prev, input logic cur);
        return prev & ~cur;
    endfunction

    // Pins pass two flops; a third feeds edge detectors
    localparam int PIN_W = 23;
    localparam logic [PIN_W-1:0] PIN_IDLE = 23'h0001E4; // Idle levels: no false edge at reset
    wire [PIN_W-1:0] pin_raw = {data_bus_upper_in, data_bus_lower_in, addr_ctrl_inputs,
                                bus_style_select, port_dir_write_n, port_read_strobe_n,
                                port_chip_select_n, backplane_frame_pulse_n_in,
                                backplane_clock_4m_in, sync_source_select,
                                tx_multiframe_align_n, rx_line_neg, rx_line_pos};
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic [PIN_W-1:0] pin_s3;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1 <= PIN_IDLE;
            pin_s2 <= PIN_IDLE;
            pin_s3 <= PIN_IDLE;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    wire       s_pos    = pin_s2[0];
    wire       s_neg    = pin_s2[1];
    wire       s_tx_multiframe_align_n_n = pin_s2[2];
    wire       s_sync   = pin_s2[3];
    wire       s_c4     = pin_s2[4];
    wire       s_f0_n   = pin_s2[5];
    wire       s_cs_n   = pin_s2[6];
    wire       s_rd_n   = pin_s2[7];
    wire       s_wr_n   = pin_s2[8];
    wire       s_style  = pin_s2[9];
    wire [4:0] s_addr   = pin_s2[14:10];
    wire [7:0] s_data   = pin_s2[22:15];

    // Control registers
    logic [7:0] ctrl;
    logic [3:0] cas_offset;
    wire  [2:0] rate_sel = ctrl[CTRL_RATE_LSB +: 3];
    wire        mf_src   = ctrl[CTRL_MF_SRC_BIT];

    // Line rate generator, re-phased on each received mark
    logic [31:0] line_acc;
    logic        seen_pos;
    logic        seen_neg;
    wire  [32:0] line_sum   = {1'b0, line_acc} + {1'b0, LINE_NCO_INC};
    wire         mark_start = rose(pin_s3[0], s_pos) | rose(pin_s3[1], s_neg);
    wire         late_mark  = mark_start & (line_acc[31:30] == LATE_PHASE);
    wire         bit_en     = line_sum[32] | late_mark;
    wire  [31:0] next_line_acc = mark_start ? LINE_ALIGN_PHASE : line_sum[31:0];

    // Marks gathered over a bit, handed over at its end
    wire next_seen_pos = bit_en ? (s_pos & mark_start) : (seen_pos | s_pos);
    wire next_seen_neg = bit_en ? (s_neg & mark_start) : (seen_neg | s_neg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_acc <= '0;
            seen_pos <= 1'b0;
            seen_neg <= 1'b0;
            recovered_line_clock <= 1'b0;
        end else begin
            line_acc <= next_line_acc;
            seen_pos <= next_seen_pos;
            seen_neg <= next_seen_neg;
            recovered_line_clock <= ~next_line_acc[31];
        end
    end

    logic dec_bit;
    e1p_line_decode u_decode (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .bit_en   (bit_en),
        .mark_pos (seen_pos),
        .mark_neg (seen_neg),
        .data_out (dec_bit)
    );

    // Free-running bit and frame counts, no frame search
    logic [7:0] rx_bit;
    logic [3:0] rx_frame;
    wire  [7:0] next_rx_bit   = rx_bit + 8'h01;
    wire  [3:0] next_rx_frame = (rx_bit == FRAME_BIT_LAST) ? rx_frame + 4'h1 : rx_frame;
    wire  [3:0] next_cas_frame = next_rx_frame + cas_offset;
    wire  [3:0] next_mf_frame  = mf_src ? next_rx_frame : next_cas_frame;
    wire        next_marker    = (next_mf_frame == MF_FRAME_LAST) &&
                                 (next_rx_bit == FRAME_BIT_LAST);

    // Gapped clock spans 1 to 5 spare bits of odd frames
    wire [2:0] sa_count  = (rate_sel > RATE_SEL_MAX) ? RATE_SEL_MAX : rate_sel;
    wire       sa_window = rx_frame[0] && (rx_bit >= SA_FIRST_BIT) &&
                           (rx_bit <= SA_FIRST_BIT + {5'h00, sa_count});
    // Next phase, so it falls as the recovered clock rises
    wire       next_gapped = sa_window & next_line_acc[31];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_bit <= '0;
            rx_frame <= '0;
            rx_link_serial_out <= 1'b0;
            rx_pcm_stream_out <= 1'b0;
            rx_multiframe_marker <= 1'b0;
            rx_link_gapped_clock <= 1'b0;
        end else begin
            rx_link_gapped_clock <= next_gapped;
            if (bit_en) begin
                rx_bit <= next_rx_bit;
                rx_frame <= next_rx_frame;
                rx_link_serial_out <= dec_bit;
                rx_pcm_stream_out <= dec_bit;
                rx_multiframe_marker <= next_marker;
            end
        end
    end

    // Backplane timing: own rate when driving, pin edges otherwise
    logic [31:0] bp_acc;
    logic [8:0]  bp_cnt;
    logic [3:0]  tx_frame;
    wire  [32:0] bp_sum     = {1'b0, bp_acc} + {1'b0, BP_NCO_INC};
    wire         bp_tick    = s_sync ? rose(pin_s3[4], s_c4) : bp_sum[32];
    wire         bp_restart = s_sync & bp_tick & ~s_f0_n;
    wire         bp_wrap    = bp_tick & (bp_cnt == BP_COUNT_LAST);
    wire         tx_align   = fell(pin_s3[2], s_tx_multiframe_align_n_n);
    wire         tx_mf_end  = bp_wrap & (tx_frame == MF_FRAME_LAST);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bp_acc <= '0;
            bp_cnt <= '0;
            tx_frame <= '0;
            tx_multiframe_boundary <= 1'b0;
            backplane_clock_4m_out <= 1'b0;
            backplane_frame_pulse_n_out <= 1'b1;
        end else begin
            bp_acc <= bp_sum[31:0];
            backplane_clock_4m_out <= ~bp_sum[31];
            backplane_frame_pulse_n_out <= ~(bp_cnt == BP_COUNT_LAST);
            tx_multiframe_boundary <= tx_align | tx_mf_end;
            if (bp_restart) begin
                bp_cnt <= '0;
            end else if (bp_tick) begin
                bp_cnt <= bp_cnt + 9'h001;
            end
            // External alignment wins over the free count
            if (tx_align) begin
                tx_frame <= '0;
            end else if (bp_wrap) begin
                tx_frame <= tx_frame + 4'h1;
            end
        end
    end

    // Backplane pin direction follows sync source
    assign backplane_clock_4m_oe      = ~s_sync;
    assign backplane_frame_pulse_n_oe = ~s_sync;

    // Processor port decode for both bus styles
    wire port_sel = ~s_cs_n;
    wire ds_act   = port_sel & ~s_rd_n;
    wire rd_req   = s_style ? ds_act : (ds_act & s_wr_n);
    wire wr_req   = s_style ? (port_sel & ~s_wr_n)
                            : (ds_act & ~s_wr_n);

    e1p_port_state_e p_state;
    e1p_port_state_e next_p_state;
    logic [7:0]      port_mem [PORT_DEPTH];
    logic [4:0]      port_waddr;
    logic [7:0]      port_wdata;
    logic [7:0]      port_rdata;
    wire             port_commit = (p_state == P_WRITE) && !wr_req;

    always_comb begin
        next_p_state = p_state;
        case (p_state)
            P_IDLE: begin
                if (rd_req) begin
                    next_p_state = P_READ;
                end else if (wr_req) begin
                    next_p_state = P_WRITE;
                end
            end
            P_READ: begin
                if (!rd_req) begin
                    next_p_state = P_IDLE;
                end
            end
            P_WRITE: begin
                if (!wr_req) begin
                    next_p_state = P_IDLE;
                end
            end
            default: next_p_state = P_IDLE;
        endcase
    end

    // Write data taken during the strobe, stored at its end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            p_state    <= P_IDLE;
            port_waddr <= '0;
            port_wdata <= '0;
            port_rdata <= '0;
        end else begin
            p_state    <= next_p_state;
            port_rdata <= (s_addr == PORT_CTRL_ADDR) ? ctrl : port_mem[s_addr];
            if (wr_req) begin
                port_waddr <= s_addr;
                port_wdata <= s_data;
            end
        end
    end

    // Port scratch bytes; control address held apart
    always_ff @(posedge aclk) begin
        if (port_commit) begin
            port_mem[port_waddr] <= port_wdata;
        end
    end

    // Pins released unless a selected read runs
    wire port_drive = (p_state == P_READ) & port_sel;
    assign data_bus_lower_out = port_rdata[3:0];
    assign data_bus_upper_out = port_rdata[7:4];
    assign data_bus_lower_oe  = {4{port_drive}};
    assign data_bus_upper_oe  = {4{port_drive}};

    // Register bus slave: one write and one read in flight
    logic                  aw_held;
    logic                  w_held;
    logic [AXI_ADDR_W-1:0] wr_addr;
    logic [31:0]           wr_data;
    logic [3:0]            wr_strb;
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    wire wr_fire   = aw_held & w_held & ~s_axi_bvalid;
    wire wr_ctrl   = wr_fire && (wr_addr == CTRL_OFS) && wr_strb[0];
    wire wr_link   = wr_fire && (wr_addr == LINK_CFG_OFS) && wr_strb[0];
    wire wr_mapped = (wr_addr == CTRL_OFS) || (wr_addr == LINK_CFG_OFS);
    wire ar_fire   = s_axi_arvalid & ~s_axi_rvalid;

    wire [31:0] status_word = (32'(s_sync) << ST_SYNC_BIT) |
                              (32'(mf_src) << ST_MF_SRC_BIT) |
                              (32'(rx_frame) << ST_RX_FRAME_LSB) |
                              (32'(tx_frame) << ST_TX_FRAME_LSB);
    wire        rd_ok   = (s_axi_araddr == CTRL_OFS) || (s_axi_araddr == STATUS_OFS) ||
                          (s_axi_araddr == LINK_CFG_OFS);
    wire [31:0] rd_word = (s_axi_araddr == CTRL_OFS)     ? {24'h000000, ctrl} :
                          (s_axi_araddr == STATUS_OFS)   ? status_word :
                          (s_axi_araddr == LINK_CFG_OFS) ? {28'h0000000, cas_offset} :
                                                           32'h00000000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            wr_addr      <= '0;
            wr_data      <= '0;
            wr_strb      <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held  <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Bus write beats a same-cycle port write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl       <= CTRL_RESET;
            cas_offset <= LINK_CFG_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl <= wr_data[7:0];
            end else if (port_commit && (port_waddr == PORT_CTRL_ADDR)) begin
                ctrl <= port_wdata;
            end
            if (wr_link) begin
                cas_offset <= wr_data[3:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

//--- tb/e1p_pins_chk.sv
// Concurrent checks on the framer pin block ports
`timescale 1ns/1ps
module e1p_pins_chk (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       recovered_line_clock,
    input wire logic       rx_link_serial_out,
    input wire logic       rx_link_gapped_clock,
    input wire logic       rx_pcm_stream_out,
    input wire logic       sync_source_select,
    input wire logic       backplane_clock_4m_oe,
    input wire logic       backplane_frame_pulse_n_oe,
    input wire logic       port_chip_select_n,
    input wire logic [3:0] data_bus_lower_oe,
    input wire logic [3:0] data_bus_upper_oe
);
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Deselected cycles, saturating
    logic [2:0] idle_cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn || !port_chip_select_n) idle_cnt <= 3'h0;
        else if (idle_cnt != 3'h7) idle_cnt <= idle_cnt + 3'h1;
    end
    bus_released_a: assert property (idle_cnt > 3'h3 |-> data_bus_lower_oe == 4'h0)
        else $error("bus driven deselected");
    lanes_agree_a: assert property (data_bus_upper_oe == data_bus_lower_oe)
        else $error("lanes enabled apart");
    read_only_a: assert property (
        data_bus_lower_oe != 4'h0 |-> !$past(port_chip_select_n, 3))
        else $error("bus driven outside access");
    bp_input_a: assert property (
        sync_source_select [*5] |-> !backplane_clock_4m_oe && !backplane_frame_pulse_n_oe)
        else $error("bp pins driven as inputs");
    bp_output_a: assert property (
        !sync_source_select [*5] |-> backplane_clock_4m_oe && backplane_frame_pulse_n_oe)
        else $error("bp pins released as outputs");
    link_edge_a: assert property (
        $changed(rx_link_serial_out) |-> $rose(recovered_line_clock))
        else $error("link bit off clock edge");
    pcm_link_a: assert property (rx_pcm_stream_out == rx_link_serial_out)
        else $error("stream and link differ");
    gap_half_a: assert property (rx_link_gapped_clock |-> !recovered_line_clock)
        else $error("gapped clock high early");
endmodule
bind e1p_framer_pins e1p_pins_chk chk (.*);

//--- tb/e1p_far_end.sv
// Far-end model: line mark source, backplane timing and link data sink
`timescale 1ns/1ps
module e1p_far_end (
    input  wire logic aclk,
    input  wire logic sync_source_select,
    input  wire logic rx_link_gapped_clock,
    input  wire logic rx_link_serial_out,
    output logic      rx_line_pos,
    output logic      rx_line_neg,
    output logic      backplane_clock_4m_in,
    output logic      backplane_frame_pulse_n_in,
    output int        link_bits
);
    logic [5:0] ph = 6'h00;
    logic       pol = 1'b0;
    logic       tgl = 1'b0;
    logic       gd = 1'b0;
    // All-ones line, 61 cycles a bit; sink samples on gapped clock rise
    initial link_bits = 0;
    always @(posedge aclk) begin
        ph <= (ph == 6'h3C) ? 6'h00 : ph + 6'h01;
        pol <= (ph == 6'h3C) ? !pol : pol;
        tgl <= !tgl;
        gd <= rx_link_gapped_clock;
        if (rx_link_gapped_clock && !gd && rx_link_serial_out) link_bits <= link_bits + 1;
    end
    // Return-to-zero marks of alternating polarity, half a bit wide
    assign rx_line_pos = pol && ph < 6'h1E;
    assign rx_line_neg = !pol && ph < 6'h1E;
    // Released pins toggle so stale levels never pass
    assign backplane_clock_4m_in = sync_source_select ? ph[3] : tgl;
    assign backplane_frame_pulse_n_in = sync_source_select | tgl;
endmodule

//--- tb/e1_framer_pin_interface_tb.sv
// Self-checking bench for the framer pin block
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module e1_framer_pin_interface_tb;
    import e1p_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, rx_line_pos, rx_line_neg, recovered_line_clock, rec_d;
    logic rx_link_serial_out, rx_link_gapped_clock, rx_pcm_stream_out;
    logic rx_multiframe_marker, tx_multiframe_align_n, tx_multiframe_boundary;
    logic sync_source_select, backplane_clock_4m_in, backplane_clock_4m_out;
    logic backplane_clock_4m_oe, backplane_frame_pulse_n_in, backplane_frame_pulse_n_out;
    logic backplane_frame_pulse_n_oe, port_chip_select_n, port_read_strobe_n;
    logic port_dir_write_n, bus_style_select, host_oe;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  s_axi_wstrb, data_bus_lower_in, data_bus_lower_out, data_bus_lower_oe;
    logic [3:0]  data_bus_upper_in, data_bus_upper_out, data_bus_upper_oe;
    logic [4:0]  addr_ctrl_inputs;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, host_data;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    int          miscompares = 0, samples_checked = 0, link_bits, n, k;
    // Released bus reads inverted
    assign {data_bus_upper_in, data_bus_lower_in} = host_oe ? host_data :
        (data_bus_lower_oe[0] ? {data_bus_upper_out, data_bus_lower_out} : ~host_data);
    e1p_framer_pins DUT (.*);
    e1p_far_end far (.*);
    // Clock at 8 ns
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    task automatic report_and_stop();
        $display("checked %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic hang();
        miscompares++;
        report_and_stop();
    endtask
    // Both write halves offered, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (n = 0; n < 40 && !(s_axi_bvalid && s_axi_bready); n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        if (n == 40) hang();
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, r)
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (n = 0; n < 40 && !(s_axi_rvalid && s_axi_rready); n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        if (n == 40) hang();
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rdata & m, e)
        `CHK(s_axi_rresp, r)
    endtask
    // Port access; style settles before select falls
    task automatic port(input logic sty, wr, input logic [4:0] a, input logic [7:0] d);
        bus_style_select <= sty;
        repeat (3) @(posedge aclk);
        addr_ctrl_inputs <= a;
        host_data <= d;
        host_oe <= wr;
        port_dir_write_n <= !wr;
        port_read_strobe_n <= wr && sty;
        port_chip_select_n <= 1'b0;
        for (k = 0; k < 20 && (wr ? k < 6 : data_bus_lower_oe !== 4'hF); k++) @(posedge aclk);
        if (k == 20) hang();
        if (!wr) `CHK({data_bus_upper_in, data_bus_lower_in}, d)
        {port_chip_select_n, port_read_strobe_n, port_dir_write_n, host_oe} <= 4'hE;
        repeat (6) @(posedge aclk);
        `CHK(data_bus_lower_oe, 4'h0)
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, host_data, addr_ctrl_inputs} = 0;
        {port_read_strobe_n, port_dir_write_n, port_chip_select_n, tx_multiframe_align_n} = 4'hF;
        {sync_source_select, bus_style_select, host_oe} = 3'h0;
        s_axi_wstrb = 4'hF;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_wr(CTRL_OFS, 32'h40, RESP_OKAY);
        axi_rd(CTRL_OFS, 32'hFF, 32'h40, RESP_OKAY);
        axi_rd(STATUS_OFS, 32'h2, 32'h2, RESP_OKAY);
        axi_wr(8'h40, 32'h1, RESP_SLVERR);
        axi_rd(8'h40, 32'hFFFF_FFFF, 32'h0, RESP_SLVERR);
        port(1'b1, 1'b1, PORT_CTRL_ADDR, 8'h44);
        axi_rd(CTRL_OFS, 32'hFF, 32'h44, RESP_OKAY);
        port(1'b1, 1'b1, 5'h01, 8'hA5);
        port(1'b1, 1'b0, 5'h01, 8'hA5);
        port(1'b0, 1'b1, 5'h02, 8'h3C);
        port(1'b0, 1'b0, 5'h02, 8'h3C);
        port(1'b0, 1'b0, PORT_CTRL_ADDR, 8'h44);
        sync_source_select <= 1'b1;
        repeat (6) @(posedge aclk);
        `CHK({backplane_clock_4m_oe, backplane_frame_pulse_n_oe}, 2'b00)
        sync_source_select <= 1'b0;
        repeat (6) @(posedge aclk);
        `CHK({backplane_clock_4m_oe, backplane_frame_pulse_n_oe}, 2'b11)
        // Two frames at 61 cycles a bit; rate 4 gives five samples
        repeat (2000) @(posedge aclk);
        n = link_bits;
        k = 0;
        rec_d = recovered_line_clock;
        repeat (31232) begin
            @(posedge aclk);
            k += int'(recovered_line_clock & ~rec_d);
            rec_d = recovered_line_clock;
        end
        `CHK(k, 512)
        `CHK(link_bits - n, 5)
        `CHK(rx_link_serial_out, 1'b1)
        // Align pulse zeroes the transmit frame count, by now nonzero
        tx_multiframe_align_n <= 1'b0;
        repeat (4) @(posedge aclk);
        tx_multiframe_align_n <= 1'b1;
        repeat (6) @(posedge aclk);
        axi_rd(STATUS_OFS, 32'hF00, 32'h0, RESP_OKAY);
        report_and_stop();
    end
endmodule
